/* File: rtl/cg_pkg.sv */
// cg_pkg: constants and carrier types for the cpu system register bank
// assumes: included by every cg_ design file through cg_pkg::*
package cg_pkg;

  // ----------------------------------------------------------------------
  // register offsets in the cpu i/o window
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_GUARD  = 4'h4;
  localparam logic [3:0] OFS_DEXT   = 4'h8;
  localparam logic [3:0] OFS_XEXT   = 4'h9;
  localparam logic [3:0] OFS_YEXT   = 4'ha;
  localparam logic [3:0] OFS_ZEXT   = 4'hb;
  localparam logic [3:0] OFS_JEXT   = 4'hc;
  localparam logic [3:0] OFS_SP_LO  = 4'hd;
  localparam logic [3:0] OFS_SP_HI  = 4'he;
  localparam logic [3:0] OFS_FLAGS  = 4'hf;

  // ----------------------------------------------------------------------
  // guard signatures, guard read bits, window length
  // ----------------------------------------------------------------------
  localparam logic [7:0] SIG_IO      = 8'hd8;
  localparam logic [7:0] SIG_PROG    = 8'h9d;
  localparam int         GUARD_IO_B  = 0;
  localparam int         GUARD_PRG_B = 1;
  localparam int         WIN_CYCLES  = 4;

  // ----------------------------------------------------------------------
  // cpu flag positions and reset values
  // ----------------------------------------------------------------------
  localparam int         FLG_I = 7;
  localparam int         FLG_T = 6;
  localparam int         FLG_H = 5;
  localparam int         FLG_S = 4;
  localparam int         FLG_V = 3;
  localparam int         FLG_N = 2;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  localparam logic [7:0] RST_EXT   = 8'h00;

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } cg_io_req_t;

  typedef struct packed {
    logic       instr_step;
    logic       dmem_wr;
    logic       program_store_instruction;
    logic       program_load_instruction;
    logic       sleep;
    logic       irq_en_ins;
    logic       irq_dis_ins;
    logic       bit_store;
    logic       bit_store_val;
    logic [7:0] alu_we;
    logic [7:0] alu_val;
    logic       sp_we;
    logic [15:0] sp_val;
    logic       prot_wr;
    logic       prot_chg_en;
  } cg_core_ev_t;

  typedef struct packed {
    logic [15:0] operand;
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } cg_ptr_t;

  typedef struct packed {
    logic [23:0] direct;
    logic [23:0] x;
    logic [23:0] y;
    logic [23:0] z;
    logic [23:0] jump;
  } cg_addr_t;

  typedef enum logic {
    CG_SHUT = 1'b0,
    CG_OPEN = 1'b1
  } cg_win_t;

endpackage

/* File: rtl/cg_regs.sv */
// cg_regs: cpu system registers, change guard, address extension, stack
// pointer and cpu flags
// assumes: cpu core drives io requests and events on clk; lock fuse is a pin
// What this block does
// - guard signature d8 opens protected i/o writes for four instruction cycles
// - guard signature 9d opens protected store/load for four instruction cycles
// - i/o window shuts on any i/o or memory write, store, load, sleep
// - store/load window shuts on any i/o or memory write or sleep
// - no interrupt is taken while a window is open; requests stay pending
// - guard reads bit 0 for i/o window, bit 1 for store/load window
// - guard bits seven to two always read zero
// - direct extension supplies top byte above direct operand
// - x and y extensions supply top byte above x and y pointers
// - z extension tops z pointer for data and program memory access
// - jump extension tops z pointer for extended indirect jump and call
// - only implemented extension bits exist; others read zero
// - stack pointer is sixteen bits, resets to top of internal sram
// - stack low write blocks interrupts four instructions or until high write
// - only implemented stack pointer bits exist; others read zero
// - flag bit 7 enables interrupts; only enable/disable instructions and flags register writes change it
// - flag bit 6 is written by bit-store, read by bit-load
// - flag bit 5 records half carry from the arithmetic unit
// - programmed lock fuse refuses all protected register changes
// - flag bit 4 always equals negative xor overflow
// - return address is two bytes up to 128k program, else three
`timescale 1ns/10ps
`default_nettype none
module cg_regs
  import cg_pkg::*;
#(
  parameter int          DEXT_BITS  = 8,
  parameter int          ZEXT_BITS  = 8,
  parameter int          JEXT_BITS  = 8,
  parameter int          SP_BITS    = 16,
  parameter logic [15:0] SP_TOP     = 16'hffff,
  parameter bit          PROG_LARGE = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire cg_io_req_t  io_req,
  input  wire cg_core_ev_t core_ev,
  input  wire cg_ptr_t     ptr,
  input  wire logic        lock_fuse,
  output var  logic [7:0]  io_rdata_q,
  output var  cg_addr_t    addr_q,
  output var  logic [15:0] sp_q,
  output var  logic [7:0]  flags_q,
  output var  logic        irq_ok_q,
  output var  logic        io_open_q,
  output var  logic        prog_open_q,
  output var  logic        prot_wr_grant_q,
  output var  logic        prot_ins_grant_q,
  output var  logic [1:0]  ret_bytes_q
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] ext_keep(input logic [7:0] v, input int bits);
    logic [7:0] m;
    m = 8'hff;
    for (int i = 0; i < 8; i++) begin
      if (i >= bits) begin
        m[i] = 1'b0;
      end
    end
    return v & m;
  endfunction

  function automatic logic [23:0] cat24(input logic [7:0] e, input logic [15:0] p);
    return {e, p};
  endfunction

  localparam logic [15:0] SP_MASK = 16'((17'h1 << SP_BITS) - 17'h1);

  // ----------------------------------------------------------------------
  // pin synchroniser for the lock fuse
  // ----------------------------------------------------------------------
  logic fuse_m_q, fuse_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fuse_m_q <= 1'b0;
      fuse_q   <= 1'b0;
    end else begin
      fuse_m_q <= lock_fuse;
      fuse_q   <= fuse_m_q;
    end
  end

  // ----------------------------------------------------------------------
  // write decode and protection windows
  // ----------------------------------------------------------------------
  logic guard_wr, sig_io, sig_prog, other_io_wr;
  logic io_open, prog_open, splk_open;

  assign guard_wr    = io_req.wr && io_req.addr == OFS_GUARD;
  assign sig_io      = guard_wr && io_req.wdata == SIG_IO;
  assign sig_prog    = guard_wr && io_req.wdata == SIG_PROG;
  assign other_io_wr = io_req.wr && !guard_wr;

  cg_window #(.CYCLES(WIN_CYCLES)) u_io_win (
    .clk    (clk),
    .arst_n (arst_n),
    .arm    (sig_io),
    .cancel (other_io_wr || core_ev.dmem_wr || core_ev.program_store_instruction || core_ev.program_load_instruction ||
             core_ev.sleep || (guard_wr && !sig_io)),
    .step   (core_ev.instr_step),
    .open_q (io_open)
  );

  cg_window #(.CYCLES(WIN_CYCLES)) u_prog_win (
    .clk    (clk),
    .arst_n (arst_n),
    .arm    (sig_prog),
    .cancel (other_io_wr || core_ev.dmem_wr || core_ev.sleep ||
             (guard_wr && !sig_prog)),
    .step   (core_ev.instr_step),
    .open_q (prog_open)
  );

  cg_window #(.CYCLES(WIN_CYCLES)) u_splk_win (
    .clk    (clk),
    .arst_n (arst_n),
    .arm    (io_req.wr && io_req.addr == OFS_SP_LO),
    .cancel (io_req.wr && io_req.addr == OFS_SP_HI),
    .step   (core_ev.instr_step),
    .open_q (splk_open)
  );

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [7:0]  dext_q, xext_q, yext_q, zext_q, jext_q;
  logic [7:0]  dext_d, xext_d, yext_d, zext_d, jext_d;
  logic [15:0] sp_d;
  logic [7:0]  flags_d, rdata_d;
  cg_addr_t    addr_d;

  always_comb begin
    dext_d  = dext_q;
    xext_d  = xext_q;
    yext_d  = yext_q;
    zext_d  = zext_q;
    jext_d  = jext_q;
    sp_d    = sp_q;
    flags_d = flags_q;
    rdata_d = io_rdata_q;
    if (core_ev.sp_we) begin
      sp_d = core_ev.sp_val & SP_MASK;
    end
    flags_d = (flags_q & ~core_ev.alu_we) | (core_ev.alu_val & core_ev.alu_we);
    // alu never touches the interrupt enable
    flags_d[FLG_I] = flags_q[FLG_I];
    if (core_ev.bit_store) begin
      flags_d[FLG_T] = core_ev.bit_store_val;
    end
    if (core_ev.irq_en_ins) begin
      flags_d[FLG_I] = 1'b1;
    end else if (core_ev.irq_dis_ins) begin
      flags_d[FLG_I] = 1'b0;
    end
    if (io_req.wr) begin
      unique case (io_req.addr)
        OFS_DEXT:  dext_d = ext_keep(io_req.wdata, DEXT_BITS);
        OFS_XEXT:  xext_d = ext_keep(io_req.wdata, DEXT_BITS);
        OFS_YEXT:  yext_d = ext_keep(io_req.wdata, DEXT_BITS);
        OFS_ZEXT:  zext_d = ext_keep(io_req.wdata, ZEXT_BITS);
        OFS_JEXT:  jext_d = ext_keep(io_req.wdata, JEXT_BITS);
        OFS_SP_LO: sp_d[7:0]  = io_req.wdata & SP_MASK[7:0];
        OFS_SP_HI: sp_d[15:8] = io_req.wdata & SP_MASK[15:8];
        OFS_FLAGS: flags_d = io_req.wdata;
        default: ;
      endcase
    end
    flags_d[FLG_S] = flags_d[FLG_N] ^ flags_d[FLG_V];
    if (io_req.rd) begin
      unique case (io_req.addr)
        OFS_GUARD: rdata_d = {6'h00, prog_open, io_open};
        OFS_DEXT:  rdata_d = dext_q;
        OFS_XEXT:  rdata_d = xext_q;
        OFS_YEXT:  rdata_d = yext_q;
        OFS_ZEXT:  rdata_d = zext_q;
        OFS_JEXT:  rdata_d = jext_q;
        OFS_SP_LO: rdata_d = sp_q[7:0];
        OFS_SP_HI: rdata_d = sp_q[15:8];
        OFS_FLAGS: rdata_d = flags_q;
        default:   rdata_d = 8'h00;
      endcase
    end
    addr_d.direct = cat24(dext_q, ptr.operand);
    addr_d.x      = cat24(xext_q, ptr.x);
    addr_d.y      = cat24(yext_q, ptr.y);
    addr_d.z      = cat24(zext_q, ptr.z);
    addr_d.jump   = cat24(jext_q, ptr.z);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dext_q           <= RST_EXT;
      xext_q           <= RST_EXT;
      yext_q           <= RST_EXT;
      zext_q           <= RST_EXT;
      jext_q           <= RST_EXT;
      sp_q             <= SP_TOP & SP_MASK;
      flags_q          <= RST_FLAGS;
      io_rdata_q       <= 8'h00;
      addr_q           <= '0;
      irq_ok_q         <= 1'b0;
      io_open_q        <= 1'b0;
      prog_open_q      <= 1'b0;
      prot_wr_grant_q  <= 1'b0;
      prot_ins_grant_q <= 1'b0;
      ret_bytes_q      <= 2'h2;
    end else begin
      dext_q           <= dext_d;
      xext_q           <= xext_d;
      yext_q           <= yext_d;
      zext_q           <= zext_d;
      jext_q           <= jext_d;
      sp_q             <= sp_d;
      flags_q          <= flags_d;
      io_rdata_q       <= rdata_d;
      addr_q           <= addr_d;
      irq_ok_q         <= flags_d[FLG_I] && !io_open && !prog_open && !splk_open;
      io_open_q        <= io_open;
      prog_open_q      <= prog_open;
      prot_wr_grant_q  <= core_ev.prot_wr && core_ev.prot_chg_en && io_open && !fuse_q;
      prot_ins_grant_q <= (core_ev.program_store_instruction || core_ev.program_load_instruction) && prog_open;
      ret_bytes_q      <= PROG_LARGE ? 2'h3 : 2'h2;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  guard_read_a: assert property (@(posedge clk) disable iff (!arst_n)
    io_req.rd && io_req.addr == OFS_GUARD |=>
      io_rdata_q == {6'h00, $past(prog_open), $past(io_open)})
    else $error("guard read does not show window state");

  guard_bad_sig_a: assert property (@(posedge clk) disable iff (!arst_n)
    guard_wr && !sig_io && !sig_prog |=> !io_open && !prog_open)
    else $error("stray guard value left a window open");

  io_close_a: assert property (@(posedge clk) disable iff (!arst_n)
    io_open && !guard_wr && (core_ev.dmem_wr || core_ev.sleep || core_ev.program_load_instruction) |=> !io_open)
    else $error("i/o window survived a closing event");

  io_timeout_a: assert property (@(posedge clk) disable iff (!arst_n)
    sig_io ##1 (!io_req.wr && core_ev.instr_step)[*4] |=> !io_open)
    else $error("i/o window outlived four instruction cycles");

  irq_block_a: assert property (@(posedge clk) disable iff (!arst_n)
    (io_open || prog_open) |=> !irq_ok_q)
    else $error("interrupt allowed inside a window");

  fuse_refuse_a: assert property (@(posedge clk) disable iff (!arst_n)
    prot_wr_grant_q |-> $past(fuse_q) == 1'b0 && $past(io_open))
    else $error("protected write granted while locked or shut");

  sign_flag_a: assert property (@(posedge clk) disable iff (!arst_n)
    flags_q[FLG_S] == (flags_q[FLG_N] ^ flags_q[FLG_V]))
    else $error("sign flag differs from n xor v");

  gie_source_a: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(flags_q[FLG_I]) |->
      $past(core_ev.irq_en_ins || core_ev.irq_dis_ins || (io_req.wr && io_req.addr == OFS_FLAGS)))
    else $error("interrupt enable changed without cause");

  bit_store_a: assert property (@(posedge clk) disable iff (!arst_n)
    core_ev.bit_store && !(io_req.wr && io_req.addr == OFS_FLAGS) |=>
      flags_q[FLG_T] == $past(core_ev.bit_store_val))
    else $error("bit store value lost");

  direct_addr_a: assert property (@(posedge clk) disable iff (!arst_n)
    1'b1 |=> addr_q.direct == {$past(dext_q), $past(ptr.operand)})
    else $error("direct address not formed from extension and operand");

  sp_bits_a: assert property (@(posedge clk) disable iff (!arst_n)
    (sp_q & ~SP_MASK) == 16'h0000)
    else $error("unimplemented stack pointer bit set");

endmodule
`default_nettype wire

/* File: rtl/cg_window.sv */
// cg_window: one timed protection window counted in instruction cycles
// assumes: arm, cancel and step come from logic on clk
`timescale 1ns/10ps
`default_nettype none
module cg_window
  import cg_pkg::*;
#(
  parameter int CYCLES = WIN_CYCLES
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic arm,
  input  wire logic cancel,
  input  wire logic step,
  output var  logic open_q
);

  cg_win_t    state_q, state_d;
  logic [2:0] cnt_q, cnt_d;

  // ----------------------------------------------------------------------
  // next state: arm beats cancel, cancel beats timeout
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    if (arm) begin
      state_d = CG_OPEN;
      cnt_d   = 3'h0;
    end else if (cancel) begin
      state_d = CG_SHUT;
      cnt_d   = 3'h0;
    end else if (state_q == CG_OPEN && step) begin
      if (cnt_q == 3'(CYCLES - 1)) begin
        state_d = CG_SHUT;
        cnt_d   = 3'h0;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= CG_SHUT;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign open_q = (state_q == CG_OPEN);

  win_len_a: assert property (@(posedge clk) disable iff (!arst_n)
    (state_q == CG_SHUT) || (cnt_q < 3'(CYCLES)))
    else $error("window counted past its length");

endmodule
`default_nettype wire

/* File: tb/cg_core_model.sv */
// cg_core_model: behavioural cpu core issuing i/o accesses and instruction events
// assumes: every task is entered just after a falling clk edge; all but set_ptr return on one
`timescale 1ns/10ps
`default_nettype none
module cg_core_model
  import cg_pkg::*;
(
  input  wire logic        clk,
  output var  cg_io_req_t  io_req,
  output var  cg_core_ev_t core_ev,
  output var  cg_ptr_t     ptr
);
  // ----------------------------------------------------------------------
  // one instruction slot per cyc, wr, rd, ev or prot call
  // ----------------------------------------------------------------------
  initial begin
    io_req  = '0;
    core_ev = '0;
    ptr     = '0;
  end

  // held through the rising edge, replaced at the next falling edge
  task automatic cyc(input cg_io_req_t r, input cg_core_ev_t e);
    io_req  = r;
    core_ev = e;
    @(negedge clk);
  endtask

  // slow core: cycles with no instruction completed
  task automatic idle(input int n);
    repeat (n) cyc('0, '0);
  endtask

  task automatic steps(input int n);
    cg_core_ev_t s;
    s            = '0;
    s.instr_step = 1'b1;
    repeat (n) cyc('0, s);
  endtask

  task automatic ev(input cg_core_ev_t e);
    cyc('0, e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cg_io_req_t r;
    r       = '0;
    r.wr    = 1'b1;
    r.addr  = a;
    r.wdata = d;
    cyc(r, '0);
  endtask

  task automatic rd(input logic [3:0] a);
    cg_io_req_t r;
    r      = '0;
    r.rd   = 1'b1;
    r.addr = a;
    cyc(r, '0);
  endtask

  // protected write; change-enable rides in the same access as the data
  task automatic prot(input logic chg, input logic stp);
    cg_core_ev_t e;
    e             = '0;
    e.prot_wr     = 1'b1;
    e.prot_chg_en = chg;
    e.instr_step  = stp;
    cyc('0, e);
  endtask

  task automatic set_ptr(input cg_ptr_t p);
    ptr = p;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_cpu_system_regs_change_guard.sv */
// tb_cpu_system_regs_change_guard: self-checking bench for cg_regs
// assumes: cg_core_model drives the core side; default design parameters
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_system_regs_change_guard;
  import cg_pkg::*;
  logic        clk;
  logic        arst_n;
  logic        lock_fuse;
  cg_io_req_t  io_req;
  cg_core_ev_t core_ev;
  cg_ptr_t     ptr;
  logic [7:0]  io_rdata_q;
  cg_addr_t    addr_q;
  logic [15:0] sp_q;
  logic [7:0]  flags_q;
  logic        irq_ok_q;
  logic        io_open_q;
  logic        prog_open_q;
  logic        prot_wr_grant_q;
  logic        prot_ins_grant_q;
  logic [1:0]  ret_bytes_q;
  int          mismatches;
  int          checks_done;
  logic [7:0]  exp_reg [16];
  logic [7:0]  v;
  cg_core_ev_t e;

  cg_regs i_dut (.clk(clk), .arst_n(arst_n), .io_req(io_req), .core_ev(core_ev), .ptr(ptr),
    .lock_fuse(lock_fuse), .io_rdata_q(io_rdata_q), .addr_q(addr_q), .sp_q(sp_q), .flags_q(flags_q),
    .irq_ok_q(irq_ok_q), .io_open_q(io_open_q), .prog_open_q(prog_open_q),
    .prot_wr_grant_q(prot_wr_grant_q), .prot_ins_grant_q(prot_ins_grant_q), .ret_bytes_q(ret_bytes_q));
  cg_core_model i_core (.clk(clk), .io_req(io_req), .core_ev(core_ev), .ptr(ptr));

  // ----------------------------------------------------------------------
  // checking and reporting
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [3:0] a);
    i_core.rd(a);
    chk(io_rdata_q, exp_reg[a]);
  endtask

  // write and keep the register image in step; s is recomputed from n and v
  task automatic wr_m(input logic [3:0] a, input logic [7:0] d);
    i_core.wr(a, d);
    if (a >= OFS_DEXT) exp_reg[a] = d;
    if (a == OFS_FLAGS) exp_reg[a][FLG_S] = d[FLG_N] ^ d[FLG_V];
  endtask

  // arm, pass nst steps, optional closing event, then the guarded act
  task automatic try_win(input logic [7:0] sig, input int nst, input int cls, input logic chg,
                         input logic expg);
    i_core.wr(OFS_GUARD, sig);
    i_core.steps(nst);
    if (cls == 4) begin
      i_core.wr(OFS_DEXT, exp_reg[OFS_DEXT]);
    end else if (cls >= 0) begin
      e         = '0;
      e.dmem_wr = (cls == 0);
      e.program_store_instruction     = (cls == 1);
      e.program_load_instruction     = (cls == 2);
      e.sleep   = (cls == 3);
      i_core.ev(e);
    end
    if (sig == SIG_IO) begin
      i_core.prot(chg, nst == 3);
      chk(prot_wr_grant_q, expg);
    end else begin
      e            = '0;
      e.program_store_instruction        = 1'($urandom);
      e.program_load_instruction        = !e.program_store_instruction;
      e.instr_step = (nst == 3);
      i_core.ev(e);
      chk(prot_ins_grant_q, expg);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    stop_test();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    arst_n      = 1'b0;
    lock_fuse   = 1'b0;
    mismatches  = 0;
    checks_done = 0;
    void'($urandom(33));
    foreach (exp_reg[i]) exp_reg[i] = 8'h00;
    exp_reg[OFS_SP_LO] = 8'hff;
    exp_reg[OFS_SP_HI] = 8'hff;
    repeat (6) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    for (int a = 0; a < 16; a++) rd_chk(a[3:0]);
    chk(sp_q, 24'hffff);
    chk(ret_bytes_q, 24'h2);
    $display("test reset done");

    for (int k = 0; k < 3; k++) begin
      for (int a = 8; a <= 12; a++) wr_m(a[3:0], 8'($urandom));
      i_core.set_ptr(cg_ptr_t'({$urandom, $urandom}));
      wr_m(4'h5, 8'($urandom));
      v = 8'($urandom);
      if (v == SIG_IO || v == SIG_PROG) v = 8'h00;
      wr_m(OFS_GUARD, v);
      i_core.idle(2);
      chk(addr_q.direct, {exp_reg[OFS_DEXT], ptr.operand});
      chk(addr_q.x, {exp_reg[OFS_XEXT], ptr.x});
      chk(addr_q.y, {exp_reg[OFS_YEXT], ptr.y});
      chk(addr_q.z, {exp_reg[OFS_ZEXT], ptr.z});
      chk(addr_q.jump, {exp_reg[OFS_JEXT], ptr.z});
      for (int a = 4; a <= 12; a++) rd_chk(a[3:0]);
    end
    $display("test extension done");

    wr_m(OFS_FLAGS, 8'($urandom));
    chk(flags_q, exp_reg[OFS_FLAGS]);
    e             = '0;
    e.irq_dis_ins = 1'b1;
    i_core.ev(e);
    exp_reg[OFS_FLAGS][FLG_I] = 1'b0;
    chk(flags_q, exp_reg[OFS_FLAGS]);
    e.irq_en_ins = 1'b1;
    i_core.ev(e);
    exp_reg[OFS_FLAGS][FLG_I] = 1'b1;
    chk(flags_q, exp_reg[OFS_FLAGS]);
    e               = '0;
    e.bit_store     = 1'b1;
    e.bit_store_val = ~exp_reg[OFS_FLAGS][FLG_T];
    i_core.ev(e);
    exp_reg[OFS_FLAGS][FLG_T] = e.bit_store_val;
    chk(flags_q, exp_reg[OFS_FLAGS]);
    e         = '0;
    e.alu_we  = 8'($urandom);
    e.alu_val = 8'($urandom);
    i_core.ev(e);
    // interrupt enable is never moved by the alu
    v         = e.alu_we;
    v[FLG_I]  = 1'b0;
    exp_reg[OFS_FLAGS] = (exp_reg[OFS_FLAGS] & ~v) | (e.alu_val & v);
    exp_reg[OFS_FLAGS][FLG_S] = exp_reg[OFS_FLAGS][FLG_N] ^ exp_reg[OFS_FLAGS][FLG_V];
    chk(flags_q, exp_reg[OFS_FLAGS]);
    $display("test flags done");

    i_core.wr(OFS_GUARD, SIG_IO);
    i_core.rd(OFS_GUARD);
    chk(io_rdata_q, 24'h1);
    chk(io_open_q, 24'h1);
    chk(irq_ok_q, 24'h0);
    i_core.steps(4);
    i_core.idle(2);
    chk(irq_ok_q, 24'h1);
    i_core.wr(OFS_GUARD, SIG_PROG);
    i_core.rd(OFS_GUARD);
    chk(io_rdata_q, 24'h2);
    chk(prog_open_q, 24'h1);
    chk(irq_ok_q, 24'h0);
    i_core.steps(4);
    rd_chk(OFS_GUARD);
    try_win(SIG_IO, 3, -1, 1'b1, 1'b1);
    try_win(SIG_IO, 4, -1, 1'b1, 1'b0);
    try_win(SIG_IO, 0, -1, 1'b0, 1'b0);
    i_core.wr(OFS_GUARD, SIG_IO);
    i_core.idle(6);
    i_core.prot(1'b1, 1'b0);
    chk(prot_wr_grant_q, 24'h1);
    for (int c = 0; c < 5; c++) try_win(SIG_IO, 0, c, 1'b1, 1'b0);
    try_win(SIG_PROG, 3, -1, 1'b0, 1'b1);
    try_win(SIG_PROG, 4, -1, 1'b0, 1'b0);
    try_win(SIG_PROG, 0, 0, 1'b0, 1'b0);
    try_win(SIG_PROG, 0, 3, 1'b0, 1'b0);
    lock_fuse = 1'b1;
    i_core.idle(3);
    try_win(SIG_IO, 0, -1, 1'b1, 1'b0);
    lock_fuse = 1'b0;
    i_core.idle(3);
    try_win(SIG_IO, 0, -1, 1'b1, 1'b1);
    $display("test guard done");

    wr_m(OFS_SP_LO, 8'($urandom));
    i_core.idle(1);
    chk(irq_ok_q, 24'h0);
    wr_m(OFS_SP_HI, 8'($urandom));
    i_core.idle(1);
    chk(irq_ok_q, 24'h1);
    chk(sp_q, {exp_reg[OFS_SP_HI], exp_reg[OFS_SP_LO]});
    wr_m(OFS_SP_LO, 8'($urandom));
    i_core.steps(3);
    chk(irq_ok_q, 24'h0);
    i_core.steps(1);
    i_core.idle(1);
    chk(irq_ok_q, 24'h1);
    e        = '0;
    e.sp_we  = 1'b1;
    e.sp_val = 16'($urandom);
    i_core.ev(e);
    {exp_reg[OFS_SP_HI], exp_reg[OFS_SP_LO]} = e.sp_val;
    rd_chk(OFS_SP_LO);
    rd_chk(OFS_SP_HI);
    $display("test stack done");
    stop_test();
  end
endmodule
`default_nettype wire
